/* File: pwg_pkg.sv */
// constants, register map and state type of the sixteen-channel 8-bit pwm generator
// ==========================================================================
// Overview of operation
// R1: divider select register clears on reset and on hardware standby entry.
// R2: divider select bits 7..3 ignore writes and read as zero.
// R3: divider bits 2 and 1 plus gate and source bits choose counter clock.
// R4: software never writes one into divider select bit 0.
// R5: pwm outputs 0..7 need their port one direction bit set.
// R6: pwm outputs 8..15 need their port two direction bit set.
// R7: port direction registers are 8-bit write-only, reset to zero.
// R8: in port-output mode the port data bit fixes the pin level.
// R9: pwm halt bit set stops the timer and enters module stop.
// R10: module halt control resets to 0x3FFF on reset and hardware standby.
// R11: bit 3 of halt high byte stops pwm; starts stopped.
// R12: upper duty nibble sets each basic pulse duty, 0/16 to 15/16.
// R13: extra pulse is one resolution active just before basic rising edge.
// R14: with zero upper nibble extra pulses still appear at same positions.
// R15: lower nibble n adds n extra pulses in fixed order; pulse 0 never.
// R16: gate off disables; source 0 system clock; else divide by 2,4,8,16.
// R17: resolution is one selected clock; period is 256 in 16 pulses.
// R18: polarity bit one inverts output so data sets low time.
// R19: pin carries pwm only with direction and output enable both one.
// R20: one free-running 8-bit counter serves all sixteen channels.
package pwg_pkg;
  // ========================================================================
  // register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFS_SEL = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_DIR1 = 8'h08;
  localparam logic [7:0] OFS_DIR2 = 8'h0C;
  localparam logic [7:0] OFS_LVL1 = 8'h10;
  localparam logic [7:0] OFS_LVL2 = 8'h14;
  localparam logic [7:0] OFS_HALT = 8'h18;
  localparam logic [7:0] OFS_POL = 8'h1C;
  localparam logic [7:0] OFS_OE = 8'h20;
  localparam logic [7:0] OFS_DUTY = 8'h24;
  localparam logic [7:0] OFS_CNT = 8'h28;
  // ========================================================================
  // field positions
  localparam int SEL_GATE_BIT = 7;
  localparam int SEL_SRC_BIT = 6;
  localparam int DIV_LSB = 1;
  localparam int HALT_PWM_BIT = 11;
  localparam logic [7:0] SEL_WR_MASK = 8'hCF;
  localparam logic [7:0] SEL_FIXED_ONES = 8'h20;
  // ========================================================================
  // reset values
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [1:0] DIV_RST = 2'h0;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [15:0] HALT_RST = 16'h3FFF;
  localparam logic [15:0] WIDE_RST = 16'h0000;
  localparam logic [7:0] DUTY_RST = 8'h00;
  // ========================================================================
  // whole state of the block
  typedef struct packed {
    logic [7:0] sel;
    logic [1:0] div;
    logic [7:0] dir1;
    logic [7:0] dir2;
    logic [7:0] lvl1;
    logic [7:0] lvl2;
    logic [15:0] halt;
    logic [15:0] pol;
    logic [15:0] oe;
    logic [15:0][7:0] duty;
    logic [3:0] pre;
    logic [7:0] cnt;
    logic [15:0] pins;
    logic ack;
    logic [31:0] rdat;
  } pwg_state_type;
  localparam pwg_state_type ST_RST = '{sel: SEL_RST, div: DIV_RST, dir1: PORT_RST, dir2: PORT_RST,
    lvl1: PORT_RST, lvl2: PORT_RST, halt: HALT_RST, pol: WIDE_RST, oe: WIDE_RST,
    duty: {16{DUTY_RST}}, pre: 4'h0, cnt: 8'h00, pins: 16'h0000, ack: 1'b0, rdat: 32'h0000_0000};
endpackage

/* File: pwg_pwm16.sv */
// sixteen-channel 8-bit pwm generator with wishbone register slave
//
// The implementer's own choices: the register offsets and register access over Wishbone.
module pwg_pwm16 (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic hw_standby_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  output logic [15:0] pin_o,
  output logic [15:0] pin_oe_o
);
  import pwg_pkg::*;

  pwg_state_type q_r;
  pwg_state_type q_nxt;
  logic wr;
  logic tick;
  logic halted;
  logic [3:0] mask;
  logic [3:0] lo;
  logic [3:0] rank;
  logic [3:0] dh;
  logic [15:0] act;
  logic [31:0] rd;
  logic [7:0] radr;

  assign radr = {wb_adr_i[7:2], 2'b00};
  // write lands on the edge where ack is seen, as the master samples it
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && q_r.ack;
  assign halted = q_r.halt[HALT_PWM_BIT];
  assign lo = q_r.cnt[3:0];
  // basic pulse p gets an extra pulse when its fill rank is below n;
  // rank is the bit-reverse of ~p, which puts pulse 0 last, never reached
  assign rank = {~q_r.cnt[4], ~q_r.cnt[5], ~q_r.cnt[6], ~q_r.cnt[7]}; // [R15]

  // ==========================================================================
  // read mux
  always_comb begin
    rd = 32'h0000_0000;
    case (radr)
      OFS_SEL: rd = {24'h00_0000, (q_r.sel & SEL_WR_MASK) | SEL_FIXED_ONES};
      OFS_DIV: rd = {24'h00_0000, 5'h00, q_r.div, 1'b0}; // [R2]
      // write-only direction registers: software has to keep its own copy
      OFS_DIR1: rd = 32'h0000_0000; // [R7]
      OFS_DIR2: rd = 32'h0000_0000; // [R7]
      OFS_LVL1: rd = {24'h00_0000, q_r.lvl1};
      OFS_LVL2: rd = {24'h00_0000, q_r.lvl2};
      OFS_HALT: rd = {16'h0000, q_r.halt};
      OFS_POL: rd = {16'h0000, q_r.pol};
      OFS_OE: rd = {16'h0000, q_r.oe};
      OFS_DUTY: rd = {24'h00_0000, q_r.duty[q_r.sel[3:0]]};
      OFS_CNT: rd = {24'h00_0000, q_r.cnt};
      default: rd = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // prescaler mask: divide by 2, 4, 8 or 16
  // the prescaler keeps running across a divider change, so the first step after it may be short
  always_comb begin
    case (q_r.div) // [R16]
      2'b00: mask = 4'h1;
      2'b01: mask = 4'h3;
      2'b10: mask = 4'h7;
      2'b11: mask = 4'hF;
      default: mask = 4'h1;
    endcase
  end
  // one resolution step per tick; source 0 steps on every system cycle
  assign tick = q_r.sel[SEL_GATE_BIT] && (!q_r.sel[SEL_SRC_BIT] || ((q_r.pre & mask) == mask)); // [R3] [R16] [R17]

  // ==========================================================================
  // channel waveforms: basic pulse sits at the end of each 16-step slot so
  // the one-step extra pulse lands right before its rising edge
  always_comb begin
    // duty zero never goes active: a steady full-on level needs port-output mode
    act = 16'h0000;
    dh = 4'h0;
    for (int i = 0; i < 16; i++) begin
      dh = q_r.duty[i][7:4];
      act[i] = (lo > ~dh) || ((lo == ~dh) && (rank < q_r.duty[i][3:0])); // [R12] [R13] [R14] [R15]
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    q_nxt = q_r;
    // bus answer: one ack per request, dropped in the next cycle
    q_nxt.ack = wb_cyc_i && wb_stb_i && !q_r.ack;
    if (wb_cyc_i && wb_stb_i && !q_r.ack) begin
      q_nxt.rdat = rd;
    end
    if (wr && wb_sel_i[0]) begin
      case (radr)
        OFS_SEL: q_nxt.sel = wb_dat_i[7:0] & SEL_WR_MASK;
        OFS_DIV: q_nxt.div = wb_dat_i[DIV_LSB +: 2]; // [R2] [R4]
        OFS_DIR1: q_nxt.dir1 = wb_dat_i[7:0]; // [R7]
        OFS_DIR2: q_nxt.dir2 = wb_dat_i[7:0]; // [R7]
        OFS_LVL1: q_nxt.lvl1 = wb_dat_i[7:0];
        OFS_LVL2: q_nxt.lvl2 = wb_dat_i[7:0];
        OFS_HALT: q_nxt.halt[7:0] = wb_dat_i[7:0];
        OFS_POL: q_nxt.pol[7:0] = wb_dat_i[7:0];
        OFS_OE: q_nxt.oe[7:0] = wb_dat_i[7:0];
        OFS_DUTY: q_nxt.duty[q_r.sel[3:0]] = wb_dat_i[7:0];
        default: q_nxt.rdat = q_nxt.rdat;
      endcase
    end
    // high byte lanes of the 16-bit registers
    if (wr && wb_sel_i[1]) begin
      case (radr)
        OFS_HALT: q_nxt.halt[15:8] = wb_dat_i[15:8]; // [R11]
        OFS_POL: q_nxt.pol[15:8] = wb_dat_i[15:8];
        OFS_OE: q_nxt.oe[15:8] = wb_dat_i[15:8];
        default: q_nxt.rdat = q_nxt.rdat;
      endcase
    end
    // time base: single counter for all channels
    // duties are lost in module stop, so software must rewrite them after release
    if (halted) begin
      q_nxt.pre = 4'h0; // [R9]
      q_nxt.cnt = 8'h00; // [R9]
      q_nxt.duty = {16{DUTY_RST}}; // module stop also clears the duty values
    end else if (q_r.sel[SEL_GATE_BIT]) begin
      q_nxt.pre = q_r.pre + 4'h1;
      if (tick) begin
        q_nxt.cnt = q_r.cnt + 8'h01; // [R20]
      end
    end else begin
      q_nxt.pre = 4'h0;
    end
    // pin mux: pwm, port level, or released
    for (int i = 0; i < 16; i++) begin
      if (i < 8) begin
        q_nxt.pins[i] = (q_r.dir1[i] && q_r.oe[i]) ? (act[i] ^ q_r.pol[i]) : q_r.lvl1[i]; // [R5] [R8] [R18] [R19]
      end else begin
        q_nxt.pins[i] = (q_r.dir2[i - 8] && q_r.oe[i]) ? (act[i] ^ q_r.pol[i]) : q_r.lvl2[i - 8]; // [R6] [R8] [R19]
      end
    end
    // hardware standby behaves like reset; a bus cycle open then is not answered
    if (hw_standby_i) begin
      q_nxt = ST_RST; // [R1] [R10]
    end
  end

  // ==========================================================================
  // state register; enable low freezes everything but reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= ST_RST; // [R1] [R10]
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

  assign wb_dat_o = q_r.rdat;
  assign wb_ack_o = q_r.ack;
  assign pin_o = q_r.pins;
  // direction alone enables the driver; input mode floats the pin
  assign pin_oe_o = {q_r.dir2, q_r.dir1}; // [R5] [R6] [R19]

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // standby must leave divider, halt and port one direction state as reset leaves it
  property p_standby;
    ce_i && hw_standby_i |=> q_r.div == DIV_RST && q_r.halt == HALT_RST && q_r.dir1 == PORT_RST;
  endproperty
  a_standby: assert property (p_standby) else $error("standby did not restore registers"); // [R1] [R10]

  // reserved divider select bits read as zero whatever was written
  property p_div_read;
    wb_ack_o && !wb_we_i && radr == OFS_DIV |-> wb_dat_o[7:3] == 5'h00 && !wb_dat_o[0];
  endproperty
  a_div_read: assert property (p_div_read) else $error("divider select reserved bits not zero"); // [R2]

  // write-only direction registers give nothing back on a read
  property p_dir_read;
    wb_ack_o && !wb_we_i && (radr == OFS_DIR1 || radr == OFS_DIR2) |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction register readable"); // [R7]

  // two halted cycles in a row leave the time base and the channel 0 duty cleared
  property p_halt_stops;
    ce_i && halted ##1 ce_i && halted |=> q_r.cnt == 8'h00 && q_r.duty[0] == DUTY_RST;
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("halted timer still runs"); // [R9] [R11]

  // system clock source: one counter step per enabled cycle
  property p_full_speed;
    ce_i && !hw_standby_i && !halted && q_r.sel[SEL_GATE_BIT] && !q_r.sel[SEL_SRC_BIT]
      |=> q_r.cnt == $past(q_r.cnt) + 8'h01;
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("system clock source did not step"); // [R16] [R20]

  // gate off: the counter must not move unless module stop clears it
  property p_gate_off;
    ce_i && !hw_standby_i && !halted && !q_r.sel[SEL_GATE_BIT] |=> $stable(q_r.cnt);
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("disabled clock still steps"); // [R16]

  // port-output mode on pin 0 shows the level bit, polarity not applied
  property p_port_level;
    ce_i && !hw_standby_i && q_r.dir1[0] && !q_r.oe[0] |=> pin_o[0] == $past(q_r.lvl1[0]);
  endproperty
  a_port_level: assert property (p_port_level) else $error("port output level wrong"); // [R8] [R19]

  // an all-zero duty value must never produce an active step
  property p_zero_duty;
    q_r.duty[0] == 8'h00 |-> !act[0];
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty produced pulse"); // [R12] [R15]

  // top nibble 15 keeps channel 15 active on every step but the first of a slot
  property p_full_nibble;
    q_r.duty[15][7:4] == 4'hF && lo != 4'h0 |-> act[15];
  endproperty
  a_full_nibble: assert property (p_full_nibble) else $error("15/16 basic pulse wrong"); // [R12]

  // a lone extra pulse belongs to the last step of basic pulse 15
  property p_extra_last;
    q_r.duty[0] == 8'h01 |-> act[0] == (q_r.cnt == 8'hFF);
  endproperty
  a_extra_last: assert property (p_extra_last) else $error("single extra pulse misplaced"); // [R13] [R14] [R15]

  // pwm mode on pin 0: registered waveform with polarity applied
  property p_pwm_pin;
    ce_i && !hw_standby_i && q_r.dir1[0] && q_r.oe[0] |=> pin_o[0] == ($past(act[0]) ^ $past(q_r.pol[0]));
  endproperty
  a_pwm_pin: assert property (p_pwm_pin) else $error("pwm pin value wrong"); // [R18] [R19]

  // a write of a direction register lands at the acknowledged edge
  property p_dir_write;
    ce_i && !hw_standby_i && wr && wb_sel_i[0] && radr == OFS_DIR2
      |=> q_r.dir2 == $past(wb_dat_i[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost"); // [R6] [R7]

  // the pwm halt bit follows the high byte lane of a halt control write
  property p_halt_write;
    ce_i && !hw_standby_i && wr && wb_sel_i[1] && radr == OFS_HALT
      |=> halted == $past(wb_dat_i[HALT_PWM_BIT]);
  endproperty
  a_halt_write: assert property (p_halt_write) else $error("halt bit write lost"); // [R9] [R11]

  // only the two divider bits take write data; the rest stays zero
  property p_div_write;
    ce_i && !hw_standby_i && wr && wb_sel_i[0] && radr == OFS_DIV
      |=> q_r.div == $past(wb_dat_i[DIV_LSB +: 2]);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider select write lost"); // [R2] [R3]

  // between prescaler ticks the time base must hold its value
  property p_tick_hold;
    ce_i && !hw_standby_i && !halted && !tick
      |=> $stable(q_r.cnt);
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("counter moved without a tick"); // [R16] [R17]

  // every tick moves the shared counter by exactly one resolution
  property p_tick_step;
    ce_i && !hw_standby_i && !halted && tick
      |=> q_r.cnt == $past(q_r.cnt) + 8'h01;
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("tick did not step counter"); // [R17] [R20]

  // port-output mode on pin 15 shows the port two level bit
  property p_port_two_level;
    ce_i && !hw_standby_i && q_r.dir2[7] && !q_r.oe[15]
      |=> pin_o[15] == $past(q_r.lvl2[7]);
  endproperty
  a_port_two_level: assert property (p_port_two_level) else $error("port two output level wrong"); // [R6] [R8]

  // pwm mode on pin 15: registered waveform with polarity applied
  property p_pwm_pin_high;
    ce_i && !hw_standby_i && q_r.dir2[7] && q_r.oe[15]
      |=> pin_o[15] == ($past(act[15]) ^ $past(q_r.pol[15]));
  endproperty
  a_pwm_pin_high: assert property (p_pwm_pin_high) else $error("port two pwm pin value wrong"); // [R6] [R18] [R19]

  // standby releases every pin driver and answers no bus cycle
  property p_standby_pins;
    ce_i && hw_standby_i
      |=> pin_oe_o == 16'h0000 && !wb_ack_o;
  endproperty
  a_standby_pins: assert property (p_standby_pins) else $error("standby left a pin driven"); // [R7] [R19]

  c_wrap: cover property (q_r.cnt == 8'hFF ##1 q_r.cnt == 8'h00);
  c_extra: cover property (act[4] && lo == ~q_r.duty[4][7:4]);
  c_div16: cover property (tick && q_r.sel[SEL_SRC_BIT] && q_r.div == 2'b11);
  // further scenarios: an inverted pwm channel and a standby pulse
  c_inverted: cover property (q_r.dir1[0] && q_r.oe[0] && q_r.pol[0]);
  c_standby: cover property (ce_i && hw_standby_i);
endmodule

/* File: pwg_load_model.sv */
// load model on the pwm pins: counts driven-high cycles of one channel
module pwg_load_model (
  // clock and control
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [3:0] ch_i,
  // pins
  input wire logic [15:0] pin_i,
  input wire logic [15:0] pin_oe_i,
  // result
  output logic [15:0] high_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_r;
  logic [15:0] wire_lvl;
  // an undriven pin floats; shown as the inverse of its last level
  assign wire_lvl = (pin_i & pin_oe_i) | (~last_r & ~pin_oe_i);
  // only driven cycles count, so a floating pin cannot fake duty
  always_ff @(posedge clk_i) begin
    last_r <= wire_lvl;
    if (clr_i) begin
      high_cnt_o <= 16'h0000;
    end else if (wire_lvl[ch_i] && pin_oe_i[ch_i]) begin
      high_cnt_o <= high_cnt_o + 16'h0001;
    end
  end
endmodule

/* File: pwg_pwm16_test.sv */
// register-level testbench of the sixteen-channel pwm generator
module pwg_pwm16_test
  import pwg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, ce_i, hw_standby_i, cyc, stb, we, clr, wb_ack_o;
  logic [7:0] adr;
  logic [3:0] sel, ch;
  logic [31:0] wdat, rd, wb_dat_o;
  logic [15:0] pin_o, pin_oe_o, high_cnt;
  logic [7:0] duty_tab [5] = '{8'h00, 8'h01, 8'h0F, 8'h80, 8'hFF};
  int failures, total_checks;
  // ==========================================
  // instances
  pwg_pwm16 i_pwg_pwm16 (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .hw_standby_i(hw_standby_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  pwg_load_model i_pwg_load_model (.clk_i(clk_i), .clr_i(clr), .ch_i(ch), .pin_i(pin_o),
    .pin_oe_i(pin_oe_o), .high_cnt_o(high_cnt));
  // ==========================================
  // tasks
  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // classic cycle; held until ack is sampled high, a hang ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      final_report();
    end
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(name, rd, exp);
  endtask
  // counts driven-high cycles over a window of whole periods
  task automatic meas(input string name, input int n, input logic [15:0] exp);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    check(name, {16'h0000, high_cnt}, {16'h0000, exp});
  endtask
  // ==========================================
  // clock and sequence
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, ce_i, hw_standby_i, cyc, stb, we, clr} = 7'b1100000;
    {adr, sel, ch, wdat, failures, total_checks} = '0;
    sel = 4'hF;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("sel", OFS_SEL, 32'h20);
    rdc("div", OFS_DIV, 32'h00);
    rdc("dir1", OFS_DIR1, 32'h00);
    rdc("lvl2", OFS_LVL2, 32'h00);
    rdc("halt", OFS_HALT, 32'h3FFF);
    rdc("unmapped", 8'h3C, 32'h00);
    wr(OFS_DIV, 32'hFE); // bit 0 kept clear
    rdc("div", OFS_DIV, 32'h06);
    wr(OFS_SEL, 32'hFF);
    rdc("sel", OFS_SEL, 32'hEF);
    wr(OFS_DIR1, 32'h01);
    wr(OFS_DIR2, 32'h80);
    rdc("dir2", OFS_DIR2, 32'h00);
    wr(OFS_LVL1, 32'h01);
    rdc("lvl1", OFS_LVL1, 32'h01);
    check("pin oe", {16'h0000, pin_oe_o}, 32'h8001);
    check("port pin", {31'h0, pin_o[0]}, 32'h1);
    wr(OFS_HALT, 32'h37FF);
    rdc("halt", OFS_HALT, 32'h37FF);
    wr(OFS_OE, 32'h8001);
    // both ports, every duty class including the zero upper nibble
    for (int k = 0; k < 2; k++) begin
      ch <= 4'(k * 15);
      wr(OFS_SEL, 32'h80 | (k * 15));
      foreach (duty_tab[i]) begin
        wr(OFS_DUTY, {24'h0, duty_tab[i]});
        meas("high time", 256, {8'h00, duty_tab[i]});
      end
    end
    ch <= 4'h0;
    wr(OFS_SEL, 32'h80);
    wr(OFS_DUTY, 32'h40);
    wr(OFS_POL, 32'h0001);
    meas("inverted", 256, 16'd192);
    wr(OFS_POL, 32'h0000);
    wr(OFS_SEL, 32'hC0);
    wr(OFS_DUTY, 32'h81);
    for (int d = 0; d < 4; d++) begin
      wr(OFS_DIV, 32'(d << 1));
      meas("divided", 256 << (d + 1), 16'(129 << (d + 1)));
    end
    wr(OFS_HALT, 32'h3FFF);
    rdc("halted cnt", OFS_CNT, 32'h00);
    rdc("halted duty", OFS_DUTY, 32'h00);
    wr(OFS_SEL, 32'h00);
    wr(OFS_HALT, 32'h37FF);
    rdc("gated cnt", OFS_CNT, 32'h00);
    hw_standby_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    hw_standby_i <= 1'b0;
    rdc("halt", OFS_HALT, 32'h3FFF);
    rdc("div", OFS_DIV, 32'h00);
    rdc("sel", OFS_SEL, 32'h20);
    check("pin oe", {16'h0000, pin_oe_o}, 32'h0000);
    final_report();
  end
endmodule
